// ### common/pcnt_pkg.sv
package pcnt_pkg;

   // Control image as written by the controller, byte 0 in the low bits.
   typedef struct packed {
      logic [15:0] reserved;   // Bytes 6 and 7, written as zero.
      logic [7:0]  byte5;      // Load requests.
      logic [7:0]  byte4;      // Gate, sync, clear and acknowledge bits.
      logic [31:0] load_value; // Bytes 0 to 3.
   } ctrl_image_t;

   // Feedback image returned to the controller.
   typedef struct packed {
      logic encoder_supply_fault;
      logic load_error;
      logic parameter_error;
      logic status_clear_active;
      logic counting_down_flag;
      logic counting_up_flag;
      logic aux_input_level;
      logic gate_open_flag;
      logic load_in_progress;
      logic zero_crossing_flag;
      logic upper_limit_flag;
      logic lower_limit_flag;
      logic sync_done_flag;
   } fb_image_t;

   // Request/answer handshake states.
   typedef enum logic [0:0] {
      HS_IDLE   = 1'b0,
      HS_ACTIVE = 1'b1
   } hs_state_t;

endpackage : pcnt_pkg

// ### common/pcnt_regs.svh
// Summary of operation
// (R1) Errors latch until acknowledged after cause gone
// (R2) Preload takes bytes 0-3 as pending value
// (R3) Direct load replaces count with bytes 0-3
// (R4) Status clear is a request/active handshake
// (R5) Software gate follows its control bit
// (R6) Encoder supply short sets acknowledged fault bit
// (R7) Multiple load requests or bad value: error
// (R8) Both load requests keep error until cleared
// (R9) Load error clears on next correct load
// (R10) Status clear active shown while clearing
// (R11) Aux input level mirrored in every mode
// (R12) Gate open flag while gate open, counting
// (R13) Load in progress shown while loading
// (R14) Zero crossing flag sticky until status clear
// (R15) Limit flags sticky until explicitly cleared
// (R16) Sync done flag sticky until status clear
// (R17) Sync enabled only while enable bit held
// (R18) Handshakes complete in 4 or 6 cycles
// (R19) Parameter error clears on correct parameters
// (R20) Held ack or stop: errors follow cause
// (R21) Group diagnostics raise channel diagnosis on error
// (R22) Controller writes zero to bytes 6 and 7
// (R23) Status clear request is byte 4 bit 2
// (R24) Gate inversion without aux gate: parameter error
// (R25) Request drop ends the active flag
`ifndef PCNT_REGS_SVH
`define PCNT_REGS_SVH

// Byte offsets within the control image.
`define CTRL_LOAD_VAL_OFS    4'h0
`define CTRL_BYTE4_OFS       4'h4
`define CTRL_BYTE5_OFS       4'h5
`define CTRL_RSVD_OFS        4'h6
// Bit positions inside control byte 4.
`define B4_SOFTWARE_GATE_BIT_BIT       3'h0
`define B4_SYNC_EN_BIT       3'h1
`define B4_STS_CLR_BIT       3'h2
`define B4_ERR_ACK_BIT       3'h7
// Bit positions inside control byte 5.
`define B5_LOAD_DIRECT_BIT   3'h0
`define B5_PRELOAD_BIT       3'h1
// Reset values of the held state.
`define LOAD_VALUE_RESET     32'h0000_0000
`define FLAGS_RESET          4'h0

`endif

// ### core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Asynchronous pins and their synchronised copies.
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q; // First stage, read only by the second stage.

   // Two flops per pin; the first may go metastable, so nothing else reads it.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= pin_i;
         sync_o <= meta_q;
      end
   end

endmodule : pin_sync

// ### core/position_counter_control_feedback.sv
`timescale 1ns/1ps
`include "pcnt_regs.svh"
module position_counter_control_feedback
   import pcnt_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Cyclic control image and its bus cycle strobe.
   input  wire ctrl_image_t ctrl_i,
   input  wire logic        cycle_strobe_i,
   // Other load requests of the channel.
   input  wire logic        compare1_load_request_i,
   input  wire logic        compare2_load_request_i,
   input  wire logic        output_param_load_request_i,
   // Controller state and channel parameters.
   input  wire logic        controller_stop_i,
   input  wire logic        diag_enable_i,
   input  wire logic        gate_invert_i,
   input  wire logic        aux_is_hw_gate_i,
   // Pins.
   input  wire logic        aux_digital_input_i,
   input  wire logic        encoder_supply_short_i,
   // Counter core status.
   input  wire logic        hw_gate_open_i,
   input  wire logic        counting_up_i,
   input  wire logic        counting_down_i,
   input  wire logic        no_main_direction_i,
   input  wire logic        zero_cross_evt_i,
   input  wire logic        upper_limit_evt_i,
   input  wire logic        lower_limit_evt_i,
   input  wire logic        sync_evt_i,
   input  wire logic [31:0] limit_low_i,
   input  wire logic [31:0] limit_high_i,
   // Counter core controls.
   output logic             software_gate_bit_o,
   output logic             sync_enable_o,
   output logic             load_direct_o,
   output logic             preload_o,
   output logic             compare1_load_o,
   output logic             compare2_load_o,
   output logic             output_param_load_o,
   output logic [31:0]      load_value_o,
   // Feedback image and diagnosis.
   output fb_image_t        fb_o,
   output logic             diag_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Control decode
   ////////////////////////////////////////////////////////////////////////////////

   logic software_gate_bit_req;      // Software gate bit.
   logic sync_en_req;      // Synchronisation enable bit.
   logic sts_clr_req;      // Status clear request.
   logic err_ack_req;      // Error acknowledge request.
   logic direct_req;       // Direct load request.
   logic preload_req;      // Preparatory load request.
   logic [4:0] load_reqs;  // All load requests together.
   logic any_load_req;     // At least one load request.
   logic multi_load_req;   // More than one load request.

   // Status clear request sits at byte 4 bit 2.
   // (R23) request bit place
   assign sts_clr_req = ctrl_i.byte4[`B4_STS_CLR_BIT];
   assign software_gate_bit_req = ctrl_i.byte4[`B4_SOFTWARE_GATE_BIT_BIT];
   assign sync_en_req = ctrl_i.byte4[`B4_SYNC_EN_BIT];
   assign err_ack_req = ctrl_i.byte4[`B4_ERR_ACK_BIT];
   assign direct_req  = ctrl_i.byte5[`B5_LOAD_DIRECT_BIT];
   assign preload_req = ctrl_i.byte5[`B5_PRELOAD_BIT];
   assign load_reqs   = {output_param_load_request_i, compare2_load_request_i,
                         compare1_load_request_i, preload_req, direct_req};
   assign any_load_req   = |load_reqs;
   // Any two set bits make the request ambiguous; clearing the lowest one tests it.
   assign multi_load_req = |(load_reqs & (load_reqs - 5'h01));

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ////////////////////////////////////////////////////////////////////////////////

   logic aux_level;    // Synchronised aux input.
   logic supply_short; // Synchronised encoder supply short.

   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .pin_i  ({encoder_supply_short_i, aux_digital_input_i}),
      .sync_o ({supply_short, aux_level})
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Level controls
   ////////////////////////////////////////////////////////////////////////////////

   // Gate and sync enable are taken once per bus cycle so they hold between images.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         software_gate_bit_o     <= 1'b0;
         sync_enable_o <= 1'b0;
      end else if (cycle_strobe_i) begin
         // (R5) software gate follows
         software_gate_bit_o     <= software_gate_bit_req;
         // (R17) sync enable held
         sync_enable_o <= sync_en_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Handshakes
   ////////////////////////////////////////////////////////////////////////////////

   logic clr_active; // Status clearing in progress.
   logic clr_start;  // First cycle of a status clear.
   logic ld_active;  // Load function running.
   logic ld_start;   // First cycle of a load.

   // (R4) status clear handshake
   req_ack_hs u_clear_hs (
      .clk_i    (clk_i),
      .rstn_i   (rstn_i),
      .strobe_i (cycle_strobe_i),
      .req_i    (sts_clr_req),
      .active_o (clr_active),
      .start_o  (clr_start)
   );

   // (R13) load runs while requested
   req_ack_hs u_load_hs (
      .clk_i    (clk_i),
      .rstn_i   (rstn_i),
      .strobe_i (cycle_strobe_i),
      .req_i    (any_load_req),
      .active_o (ld_active),
      .start_o  (ld_start)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Load acceptance
   ////////////////////////////////////////////////////////////////////////////////

   logic value_ok;    // Value lies in the counting range.
   logic load_good;   // Load accepted on this start.
   logic load_err_q;  // Load error feedback.

   assign value_ok  = ($signed(ctrl_i.load_value) >= $signed(limit_low_i)) &&
                      ($signed(ctrl_i.load_value) <= $signed(limit_high_i));
   assign load_good = ld_start && !multi_load_req && value_ok;

   // Accepted value and one-cycle strobes to the counter core.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         load_value_o        <= `LOAD_VALUE_RESET;
         load_direct_o       <= 1'b0;
         preload_o           <= 1'b0;
         compare1_load_o     <= 1'b0;
         compare2_load_o     <= 1'b0;
         output_param_load_o <= 1'b0;
      end else begin
         // (R3) direct load strobe
         load_direct_o       <= load_good && direct_req;
         // (R2) pending value strobe
         preload_o           <= load_good && preload_req;
         compare1_load_o     <= load_good && compare1_load_request_i;
         compare2_load_o     <= load_good && compare2_load_request_i;
         output_param_load_o <= load_good && output_param_load_request_i;
         if (load_good) begin
            load_value_o <= ctrl_i.load_value;
         end
      end
   end

   // Rejected loads set the error; only a later good load clears it.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         load_err_q <= 1'b0;
      end else if (ld_start && (multi_load_req || !value_ok)) begin
         // (R7) reject bad load
         load_err_q <= 1'b1;
      end else if (ld_active && direct_req && preload_req) begin
         // (R8) both requests persist
         load_err_q <= 1'b1;
      end else if (load_good) begin
         // (R9) good load clears
         load_err_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status flags
   ////////////////////////////////////////////////////////////////////////////////

   logic [3:0] flag_set; // Events: sync, lower, upper, zero crossing.
   logic [3:0] flag_q;   // Held flags in the same order.

   // (R14) zero crossing source
   assign flag_set[3] = zero_cross_evt_i && no_main_direction_i;
   // (R15) limit violation sources
   assign flag_set[2] = upper_limit_evt_i;
   assign flag_set[1] = lower_limit_evt_i;
   // (R16) sync done source
   assign flag_set[0] = sync_evt_i && sync_enable_o;

   // A new event in the clearing cycle wins, so no crossing is ever lost.
   for (genvar i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            flag_q[i] <= 1'b0;
         end else if (flag_set[i]) begin
            flag_q[i] <= 1'b1;
         end else if (clr_start) begin
            flag_q[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Errors
   ////////////////////////////////////////////////////////////////////////////////

   logic supply_err_q; // Encoder supply fault.
   logic para_err_q;   // Parameter error.
   logic ack_or_stop;  // The supply fault may be cleared once its cause is gone.

   assign ack_or_stop = err_ack_req || controller_stop_i;

   // The fault latches; it drops only with acknowledge or controller stop and no cause present.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         supply_err_q <= 1'b0;
      end else if (supply_short) begin
         // (R6) supply short latches
         supply_err_q <= 1'b1;
      end else if (ack_or_stop) begin
         // (R1) acknowledged after removal
         // (R20) follows cause while held
         supply_err_q <= 1'b0;
      end
   end

   // Parameter error is a pure function of the current parameter set.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         para_err_q <= 1'b0;
      end else begin
         // (R24) inversion without aux gate
         // (R19) clears on correct set
         para_err_q <= gate_invert_i && !aux_is_hw_gate_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Feedback image
   ////////////////////////////////////////////////////////////////////////////////

   // The image is registered so the controller always reads a coherent set.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fb_o   <= '0;
         diag_o <= 1'b0;
      end else begin
         fb_o.encoder_supply_fault <= supply_err_q;
         fb_o.load_error           <= load_err_q;
         fb_o.parameter_error      <= para_err_q;
         // (R10) clearing shown active
         // (R25) drops after request drop
         fb_o.status_clear_active  <= clr_active;
         fb_o.counting_down_flag   <= counting_down_i;
         fb_o.counting_up_flag     <= counting_up_i;
         // (R11) aux level mirrored
         fb_o.aux_input_level      <= aux_level;
         // (R12) gate open flag
         fb_o.gate_open_flag       <= software_gate_bit_o && hw_gate_open_i;
         fb_o.load_in_progress     <= ld_active;
         fb_o.zero_crossing_flag   <= flag_q[3];
         fb_o.upper_limit_flag     <= flag_q[2];
         fb_o.lower_limit_flag     <= flag_q[1];
         fb_o.sync_done_flag       <= flag_q[0];
         // (R21) channel diagnosis
         diag_o <= diag_enable_i && (supply_err_q || load_err_q || para_err_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_clear_seen;
      cycle_strobe_i && sts_clr_req && !clr_active;
   endsequence

   sequence s_flag_cleared;
      !flag_q[2] || flag_set[2];
   endsequence

   chk_clear_answer: assert property ( // (R4)
      s_clear_seen |-> ##2 fb_o.status_clear_active)
      else $error("status clear not answered");

   chk_clear_flags: assert property ( // (R15)
      s_clear_seen ##1 !$past(flag_set[2]) |-> s_flag_cleared)
      else $error("limit flag not cleared");

   chk_clear_release: assert property ( // (R25)
      clr_active && cycle_strobe_i && !sts_clr_req |-> ##2 !fb_o.status_clear_active)
      else $error("active flag held after request drop");

   chk_sticky_limit: assert property ( // (R15)
      flag_q[2] && !clr_start |=> flag_q[2])
      else $error("limit flag lost without clear");

   chk_multi_load: assert property ( // (R7)
      ld_start && multi_load_req |=> load_err_q && !load_direct_o && !preload_o)
      else $error("ambiguous load not rejected");

   chk_good_load: assert property ( // (R3)
      load_good && direct_req |=> load_direct_o && load_value_o == $past(ctrl_i.load_value))
      else $error("direct load not applied");

   chk_both_req: assert property ( // (R8)
      ld_active && direct_req && preload_req |=> load_err_q)
      else $error("load error dropped while both requests set");

   chk_fault_latch: assert property ( // (R1)
      supply_err_q && !supply_short && !ack_or_stop |=> supply_err_q)
      else $error("supply fault cleared without acknowledge");

   chk_gate_follow: assert property ( // (R5)
      cycle_strobe_i |=> software_gate_bit_o == $past(software_gate_bit_req))
      else $error("software gate not following");

   chk_param_error: assert property ( // (R24)
      gate_invert_i && !aux_is_hw_gate_i |=> ##1 fb_o.parameter_error)
      else $error("parameter error not reported");

endmodule : position_counter_control_feedback

// ### core/req_ack_hs.sv
`timescale 1ns/1ps
module req_ack_hs
   import pcnt_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Controller side: request level sampled on each bus cycle strobe.
   input  wire logic strobe_i,
   input  wire logic req_i,
   // Answer level and one-cycle start pulse.
   output logic      active_o,
   output logic      start_o
);

   hs_state_t state_q; // Handshake phase.

   // Enter on a seen request, leave only when the request is seen dropped.
   // (R18) bus cycle pacing
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= HS_IDLE;
      end else if (strobe_i) begin
         unique case (state_q)
            HS_IDLE: begin
               if (req_i) state_q <= HS_ACTIVE;
            end
            HS_ACTIVE: begin
               if (!req_i) state_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign active_o = (state_q == HS_ACTIVE);
   assign start_o  = strobe_i && req_i && (state_q == HS_IDLE);

endmodule : req_ack_hs

// ### sim/bus_controller_model.sv
`timescale 1ns/1ps
module bus_controller_model
   import pcnt_pkg::*;
#(
   parameter int PERIOD = 4  // Clocks per bus cycle; small keeps the run short.
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Image the application wants sent on the next bus cycle.
   input  wire ctrl_image_t img_i,
   // Cyclic control image towards the device.
   output ctrl_image_t      ctrl_o,
   output logic             strobe_o
);
   int unsigned cnt_q;  // Position inside the bus cycle.

   ////////////////////////////////////////////////////////////////////////////
   // The image is a level held for a whole bus cycle, so the device may read
   // it at any edge; only the strobe marks a new transfer.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q    <= 0;
         strobe_o <= 1'b0;
         ctrl_o   <= '0;
      end else begin
         strobe_o <= (cnt_q == PERIOD - 1);
         cnt_q    <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         if (cnt_q == PERIOD - 1) begin
            ctrl_o          <= img_i;
            ctrl_o.reserved <= 16'h0000;
         end
      end
   end
endmodule : bus_controller_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb
   import pcnt_pkg::*;
;
   localparam logic [7:0] SW = 8'h01, SYN = 8'h02, CLR = 8'h04, ACK = 8'h80;
   localparam logic [7:0] DIR = 8'h01, PRE = 8'h02;
   logic        clk_i, rstn_i, strobe, cmp1, stop, diag_en, ginv, aux_gate;
   logic        aux_pin, short_pin, hw_gate, c_up, c_dn, nomain;
   logic        ev_zero, ev_up, ev_lo, ev_sync, diag, p_dir, p_pre;
   logic        software_gate_bit, sync_en, ld_dir, ld_pre;
   logic        cmp2, opar, c1_ld, c2_ld, op_ld;
   logic [2:0]  p_cmp;
   logic [31:0] lim_lo, lim_hi, ld_val;
   ctrl_image_t img, ctrl;
   fb_image_t   fb;
   int          n_fail, total_checks;

   always #50 clk_i = ~clk_i;

   bus_controller_model #(.PERIOD(4)) u_bus_controller_model (
      .clk_i(clk_i), .rstn_i(rstn_i), .img_i(img), .ctrl_o(ctrl), .strobe_o(strobe));

   position_counter_control_feedback u_position_counter_control_feedback (
      .clk_i(clk_i), .rstn_i(rstn_i), .ctrl_i(ctrl), .cycle_strobe_i(strobe),
      .compare1_load_request_i(cmp1), .compare2_load_request_i(cmp2),
      .output_param_load_request_i(opar), .controller_stop_i(stop),
      .diag_enable_i(diag_en), .gate_invert_i(ginv), .aux_is_hw_gate_i(aux_gate),
      .aux_digital_input_i(aux_pin), .encoder_supply_short_i(short_pin),
      .hw_gate_open_i(hw_gate), .counting_up_i(c_up), .counting_down_i(c_dn),
      .no_main_direction_i(nomain), .zero_cross_evt_i(ev_zero),
      .upper_limit_evt_i(ev_up), .lower_limit_evt_i(ev_lo), .sync_evt_i(ev_sync),
      .limit_low_i(lim_lo), .limit_high_i(lim_hi), .software_gate_bit_o(software_gate_bit),
      .sync_enable_o(sync_en), .load_direct_o(ld_dir), .preload_o(ld_pre),
      .compare1_load_o(c1_ld), .compare2_load_o(c2_ld), .output_param_load_o(op_ld),
      .load_value_o(ld_val), .fb_o(fb), .diag_o(diag));

   ////////////////////////////////////////////////////////////////////////////
   // Compares with case equality so an unknown never counts as a match.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Waits n edges, then steps past them so registered outputs have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // One bus transfer: waits for the strobe that carries this image, keeps the
   // load pulses of the following cycle, then lets the feedback settle.
   task automatic send(input logic [7:0] b4, input logic [7:0] b5, input logic [31:0] v);
      int i;
      img <= {16'h0000, b5, b4, v};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (strobe === 1'b1 && ctrl === {16'h0000, b5, b4, v}) break;
      end
      if (i == 20) check("transfer", 32'h0, 32'h1);
      #1;
      p_dir = ld_dir;
      p_pre = ld_pre;
      p_cmp = {c1_ld, c2_ld, op_ld};
      tick(3);
   endtask : send

   // Pulses counter core events for one cycle.
   task automatic events(input logic [3:0] e);
      @(posedge clk_i);
      {ev_zero, ev_up, ev_lo, ev_sync} <= e;
      @(posedge clk_i);
      {ev_zero, ev_up, ev_lo, ev_sync} <= 4'h0;
      tick(4);
   endtask : events

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      stop_test();
   end

   initial begin
      {clk_i, rstn_i, cmp1, stop, ginv, aux_gate, aux_pin, short_pin} = '0;
      {hw_gate, c_up, c_dn, nomain, ev_zero, ev_up, ev_lo, ev_sync} = '0;
      diag_en = 1'b1;
      {cmp2, opar} = 2'b00;
      img = '0;
      lim_lo = 32'hFFFF_FC18;  // Counting range is -1000 to 1000.
      lim_hi = 32'h0000_03E8;
      n_fail = 0;
      total_checks = 0;
      repeat (8) @(posedge clk_i);
      check("fb in reset", 32'(fb), 32'h0);
      rstn_i <= 1'b1;
      $display("test reset done");
      @(posedge clk_i);
      {aux_pin, c_up} <= 2'b11;
      tick(5);
      check("aux level", 32'(fb.aux_input_level), 32'h1);
      check("count up", 32'(fb.counting_up_flag), 32'h1);
      @(posedge clk_i);
      {aux_pin, c_up, c_dn} <= 3'b001;
      tick(5);
      check("aux level", 32'(fb.aux_input_level), 32'h0);
      check("count down", 32'(fb.counting_down_flag), 32'h1);
      $display("test mirror done");
      hw_gate <= 1'b1;
      send(SW | SYN, 8'h00, 32'h0);
      check("software_gate_bit", 32'(software_gate_bit), 32'h1);
      check("sync en", 32'(sync_en), 32'h1);
      check("gate open", 32'(fb.gate_open_flag), 32'h1);
      send(8'h00, 8'h00, 32'h0);
      check("software_gate_bit", 32'(software_gate_bit), 32'h0);
      check("sync en", 32'(sync_en), 32'h0);
      check("gate open", 32'(fb.gate_open_flag), 32'h0);
      $display("test gate done");
      send(8'h00, DIR, 32'h0000_03E8);
      check("direct pulse", 32'(p_dir), 32'h1);
      check("load value", ld_val, 32'h0000_03E8);
      check("loading", 32'(fb.load_in_progress), 32'h1);
      send(8'h00, 8'h00, 32'h0);
      check("loading", 32'(fb.load_in_progress), 32'h0);
      send(8'h00, PRE, 32'hFFFF_FC18);
      check("pre pulse", 32'(p_pre), 32'h1);
      check("load value", ld_val, 32'hFFFF_FC18);
      send(8'h00, 8'h00, 32'h0);
      send(8'h00, DIR | PRE, 32'h0000_0005);
      check("both pulse", 32'(p_dir | p_pre), 32'h0);
      check("load error", 32'(fb.load_error), 32'h1);
      send(8'h00, 8'h00, 32'h0);
      check("error kept", 32'(fb.load_error), 32'h1);
      send(8'h00, DIR, 32'h0000_0064);
      check("error clear", 32'(fb.load_error), 32'h0);
      send(8'h00, 8'h00, 32'h0);
      send(8'h00, DIR, 32'h0000_03E9);
      check("range error", 32'(fb.load_error), 32'h1);
      check("value kept", ld_val, 32'h0000_0064);
      send(8'h00, 8'h00, 32'h0);
      // Raise the extra request only after the strobe that still carries the idle image.
      @(posedge clk_i);
      cmp1 <= 1'b1;
      send(8'h00, DIR, 32'h0000_0064);
      check("two requests", 32'(p_dir), 32'h0);
      cmp1 <= 1'b0;
      send(8'h00, 8'h00, 32'h0);
      check("error kept", 32'(fb.load_error), 32'h1);
      @(posedge clk_i);
      cmp1 <= 1'b1;
      send(8'h00, 8'h00, 32'h0000_0009);
      check("cmp1 pulse", 32'(p_cmp), 32'h4);
      check("error clear", 32'(fb.load_error), 32'h0);
      cmp1 <= 1'b0;
      send(8'h00, 8'h00, 32'h0);
      @(posedge clk_i);
      {cmp2, opar} <= 2'b11;
      send(8'h00, 8'h00, 32'h0000_0009);
      check("cmp pulses", 32'(p_cmp), 32'h0);
      check("cmp error", 32'(fb.load_error), 32'h1);
      {cmp2, opar} <= 2'b00;
      send(8'h00, 8'h00, 32'h0);
      $display("test load done");
      nomain <= 1'b1;
      events(4'h1);
      check("sync off", 32'(fb.sync_done_flag), 32'h0);
      send(SYN, 8'h00, 32'h0);
      events(4'hF);
      check("flags set", 32'(fb[3:0]), 32'hF);
      tick(4);
      check("flags held", 32'(fb[3:0]), 32'hF);
      send(SYN | CLR, 8'h00, 32'h0);
      check("flags clear", 32'(fb[3:0]), 32'h0);
      check("clear active", 32'(fb.status_clear_active), 32'h1);
      send(SYN, 8'h00, 32'h0);
      check("clear done", 32'(fb.status_clear_active), 32'h0);
      $display("test flags done");
      @(posedge clk_i);
      short_pin <= 1'b1;
      tick(6);
      check("supply fault", 32'(fb.encoder_supply_fault), 32'h1);
      check("diagnosis", 32'(diag), 32'h1);
      @(posedge clk_i);
      short_pin <= 1'b0;
      tick(6);
      check("fault latched", 32'(fb.encoder_supply_fault), 32'h1);
      send(ACK, 8'h00, 32'h0);
      check("fault acked", 32'(fb.encoder_supply_fault), 32'h0);
      send(8'h00, 8'h00, 32'h0);
      @(posedge clk_i);
      {stop, short_pin} <= 2'b11;
      tick(6);
      check("stop fault", 32'(fb.encoder_supply_fault), 32'h1);
      @(posedge clk_i);
      short_pin <= 1'b0;
      tick(6);
      check("stop clear", 32'(fb.encoder_supply_fault), 32'h0);
      stop <= 1'b0;
      @(posedge clk_i);
      ginv <= 1'b1;
      tick(4);
      check("param error", 32'(fb.parameter_error), 32'h1);
      diag_en <= 1'b0;
      tick(3);
      check("diag off", 32'(diag), 32'h0);
      aux_gate <= 1'b1;
      tick(4);
      check("param ok", 32'(fb.parameter_error), 32'h0);
      $display("test errors done");
      stop_test();
   end
endmodule : tb
